// >>> hw/divide_unit_defines.vh
// Constants for the integer divide and remainder unit.
// Assumes 32-bit instruction words with the major opcode in the top six bits.
`ifndef DIVIDE_UNIT_DEFINES_VH
`define DIVIDE_UNIT_DEFINES_VH

`define MAJOR_OPCODE_GROUP_A  6'h00
`define OPC_MSB               31
`define OPC_LSB               26
`define DIVISOR_FIELD_MSB     25
`define DIVISOR_FIELD_LSB     21
`define DIVIDEND_FIELD_MSB    20
`define DIVIDEND_FIELD_LSB    16
`define DEST_FIELD_MSB        15
`define DEST_FIELD_LSB        11
`define ZERO_BIT              10
`define FUNC_MSB              9
`define FUNC_LSB              0
`define FUNC_SIGNED_QUOT      10'h118
`define FUNC_SIGNED_REM       10'h158
`define FUNC_UNSIGNED_QUOT    10'h198
`define FUNC_UNSIGNED_REM     10'h1D8
`define OP_SIGNED_QUOT        2'h0
`define OP_SIGNED_REM         2'h1
`define OP_UNSIGNED_QUOT      2'h2
`define OP_UNSIGNED_REM       2'h3
`define WORD_WIDTH            32
`define ZERO_REG_INDEX        5'h00

`endif

// >>> hw/divide_decoder.v
// Decodes the three-register divide and remainder instructions.
// Assumes the instruction word is stable while instr_valid is high.
`timescale 1ns/1ps
`default_nettype none
`include "divide_unit_defines.vh"

module divide_decoder (
  // Instruction
  input  wire [31:0] instr,
  // Decode results
  output reg         is_divide,
  output reg  [1:0]  op_code,
  output wire [4:0]  divisor_reg_field,
  output wire [4:0]  dividend_reg_field,
  output wire [4:0]  dest_reg_field
);

  wire        group_a = (instr[`OPC_MSB:`OPC_LSB] == `MAJOR_OPCODE_GROUP_A);
  wire [9:0]  func    = instr[`FUNC_MSB:`FUNC_LSB];

  // (RULE_01) Field layout
  assign divisor_reg_field  = instr[`DIVISOR_FIELD_MSB:`DIVISOR_FIELD_LSB];
  assign dividend_reg_field = instr[`DIVIDEND_FIELD_MSB:`DIVIDEND_FIELD_LSB];
  assign dest_reg_field     = instr[`DEST_FIELD_MSB:`DEST_FIELD_LSB];

  always @* begin
    is_divide = 1'b0;
    op_code   = `OP_SIGNED_QUOT;
    // (RULE_01) Opcode and zero bit
    if (group_a && !instr[`ZERO_BIT]) begin
      case (func)
        // (RULE_02) Signed function codes
        `FUNC_SIGNED_QUOT: begin
          is_divide = 1'b1;
          op_code   = `OP_SIGNED_QUOT;
        end
        `FUNC_SIGNED_REM: begin
          is_divide = 1'b1;
          op_code   = `OP_SIGNED_REM;
        end
        // (RULE_03) Unsigned function codes
        `FUNC_UNSIGNED_QUOT: begin
          is_divide = 1'b1;
          op_code   = `OP_UNSIGNED_QUOT;
        end
        `FUNC_UNSIGNED_REM: begin
          is_divide = 1'b1;
          op_code   = `OP_UNSIGNED_REM;
        end
        default: begin
          is_divide = 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> hw/restoring_divider.v
// Unsigned restoring divider, one quotient bit per cycle.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
`default_nettype none

module restoring_divider #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst,
  // Request
  input  wire             start,
  input  wire [WIDTH-1:0] dividend,
  input  wire [WIDTH-1:0] divisor,
  // Result
  output reg              done,
  output reg  [WIDTH-1:0] quotient,
  output reg  [WIDTH-1:0] remainder
);

  localparam CW = $clog2(WIDTH + 1);
  // One iteration per quotient bit
  localparam [CW-1:0] STEPS = WIDTH;

  reg  [CW-1:0]  count_reg;
  reg            run_reg;
  reg  [WIDTH-1:0] divisor_reg;
  wire [WIDTH:0] trial = {remainder, quotient[WIDTH-1]};
  wire [WIDTH:0] diff  = trial - {1'b0, divisor_reg};

  always @(posedge clock) begin
    if (rst) begin
      count_reg   <= {CW{1'b0}};
      run_reg     <= 1'b0;
      done        <= 1'b0;
      quotient    <= {WIDTH{1'b0}};
      remainder   <= {WIDTH{1'b0}};
      divisor_reg <= {WIDTH{1'b0}};
    end else begin
      done <= 1'b0;
      if (start) begin
        run_reg     <= 1'b1;
        count_reg   <= STEPS;
        quotient    <= dividend;
        remainder   <= {WIDTH{1'b0}};
        divisor_reg <= divisor;
      end else if (run_reg) begin
        // Zero divisor just runs through; the result is left as computed
        if (!diff[WIDTH]) begin
          remainder <= diff[WIDTH-1:0];
          quotient  <= {quotient[WIDTH-2:0], 1'b1};
        end else begin
          remainder <= trial[WIDTH-1:0];
          quotient  <= {quotient[WIDTH-2:0], 1'b0};
        end
        count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
        if (count_reg == {{(CW-1){1'b0}}, 1'b1}) begin
          run_reg <= 1'b0;
          done    <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/integer_divide_modulo_unit.v
// Integer divide and remainder execution unit with register-file write port.
// Assumes the issuing stage holds instr and operands stable while busy is high.
// Behaviour
// (RULE_01) Match major opcode zero, three register fields, zero bit, function code.
// (RULE_02) Codes 0100011000 and 0101011000 select signed quotient and remainder.
// (RULE_03) Codes 0110011000 and 0111011000 select unsigned quotient and remainder.
// (RULE_04) Divide dividend by divisor, write one result to destination register.
// (RULE_05) Quotient times divisor plus remainder equals dividend; truncate toward zero.
// (RULE_06) Signed quotient on two's-complement 32-bit operands.
// (RULE_07) Signed remainder carries the dividend's sign.
// (RULE_08) Unsigned quotient on 32-bit operands.
// (RULE_09) Unsigned remainder on 32-bit operands.
// (RULE_10) No trap ever, zero divisor completes normally.
// (RULE_11) Zero divisor result value is unconstrained.
// (RULE_12) Old result-pair divide encodings raise a reserved instruction exception.
// (RULE_13) Busy stalls the pipeline until result is valid; operands held stable.
// (RULE_14) Most negative divided by minus one gives the dividend and zero.
// (RULE_15) Results addressed to register zero are discarded.
`timescale 1ns/1ps
`default_nettype none
`include "divide_unit_defines.vh"

module integer_divide_modulo_unit #(
  parameter WIDTH             = 32,
  parameter LEGACY_FUNC_MASK  = 10'h3FF,
  parameter LEGACY_DIV_FUNC   = 10'h2AC,
  parameter LEGACY_UQUOT_FUNC = 10'h2EC
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst,
  // Issue
  input  wire             instr_valid,
  input  wire [31:0]      instr,
  output wire             accepted,
  output wire             busy,
  // Register file read
  output wire [4:0]       dividend_read_index,
  output wire [4:0]       divisor_read_index,
  input  wire [WIDTH-1:0] dividend_value,
  input  wire [WIDTH-1:0] divisor_value,
  // Register file write
  output reg              write_enable,
  output reg  [4:0]       write_index,
  output reg  [WIDTH-1:0] write_data,
  // Exceptions
  output reg              reserved_instr_exc,
  output wire             arith_exc
);

  localparam S_IDLE = 2'h0;
  localparam S_RUN  = 2'h1;
  localparam S_DONE = 2'h2;

  wire             is_divide;
  wire [1:0]       op_code;
  wire [4:0]       divisor_reg_field;
  wire [4:0]       dividend_reg_field;
  wire [4:0]       dest_reg_field;

  reg  [1:0]       state_reg;
  reg  [1:0]       op_reg;
  reg  [4:0]       dest_reg;
  reg              neg_quot_reg;
  reg              neg_rem_reg;

  wire             div_done;
  wire [WIDTH-1:0] div_quot;
  wire [WIDTH-1:0] div_rem;

  divide_decoder decoder (
    .instr              (instr),
    .is_divide          (is_divide),
    .op_code            (op_code),
    .divisor_reg_field  (divisor_reg_field),
    .dividend_reg_field (dividend_reg_field),
    .dest_reg_field     (dest_reg_field)
  );

  // (RULE_04) Operand fetch indices
  assign dividend_read_index = dividend_reg_field;
  assign divisor_read_index  = divisor_reg_field;

  // (RULE_10) Never traps
  assign arith_exc = 1'b0;

  wire is_signed = (op_code == `OP_SIGNED_QUOT) || (op_code == `OP_SIGNED_REM);
  wire a_neg     = is_signed && dividend_value[WIDTH-1];
  wire b_neg     = is_signed && divisor_value[WIDTH-1];

  // (RULE_06) Magnitudes for signed operands
  wire [WIDTH-1:0] a_mag = a_neg ? (~dividend_value + 1'b1) : dividend_value;
  wire [WIDTH-1:0] b_mag = b_neg ? (~divisor_value + 1'b1) : divisor_value;

  // (RULE_12) Legacy two-operand divide with result pair
  wire [9:0] func = instr[`FUNC_MSB:`FUNC_LSB];
  wire legacy = (instr[`OPC_MSB:`OPC_LSB] == `MAJOR_OPCODE_GROUP_A) &&
                (((func & LEGACY_FUNC_MASK) == LEGACY_DIV_FUNC) ||
                 ((func & LEGACY_FUNC_MASK) == LEGACY_UQUOT_FUNC));

  wire start = (state_reg == S_IDLE) && instr_valid && is_divide;

  // (RULE_13) Stall until result written
  assign busy     = (state_reg != S_IDLE) || start;
  assign accepted = (state_reg == S_DONE);

  restoring_divider #(
    .WIDTH (WIDTH)
  ) divider (
    .clock     (clock),
    .rst       (rst),
    .start     (start),
    .dividend  (a_mag),
    .divisor   (b_mag),
    .done      (div_done),
    .quotient  (div_quot),
    .remainder (div_rem)
  );

  // (RULE_05) Truncated signs restored
  wire [WIDTH-1:0] quot_s = neg_quot_reg ? (~div_quot + 1'b1) : div_quot;
  wire [WIDTH-1:0] rem_s  = neg_rem_reg ? (~div_rem + 1'b1) : div_rem;

  // Word patterns for the two special cases
  localparam [WIDTH-1:0] MOST_NEG  = {1'b1, {(WIDTH-1){1'b0}}};
  localparam [WIDTH-1:0] ALL_ONES  = {WIDTH{1'b1}};
  localparam [WIDTH-1:0] ZERO_WORD = {WIDTH{1'b0}};

  // Operand copies taken at issue, so the special cases never depend on
  // the register file still showing the same values late in the run
  reg  [WIDTH-1:0] dividend_cap_reg;
  reg  [WIDTH-1:0] divisor_cap_reg;

  always @(posedge clock) begin
    if (rst) begin
      dividend_cap_reg <= {WIDTH{1'b0}};
      divisor_cap_reg  <= {WIDTH{1'b0}};
    end else if (start) begin
      dividend_cap_reg <= dividend_value;
      divisor_cap_reg  <= divisor_value;
    end
  end

  wire cap_signed = (op_reg == `OP_SIGNED_QUOT) || (op_reg == `OP_SIGNED_REM);
  // (RULE_11) Zero divisor seen at issue
  wire zero_div   = (divisor_cap_reg == ZERO_WORD);
  // (RULE_14) Most negative word by minus one
  wire wrap_case  = cap_signed &&
                    (dividend_cap_reg == MOST_NEG) &&
                    (divisor_cap_reg == ALL_ONES);

  // Signed results after the special cases
  reg  [WIDTH-1:0] quot_final;
  reg  [WIDTH-1:0] rem_final;
  always @* begin
    quot_final = quot_s;
    rem_final  = rem_s;
    // (RULE_14) Wrapped quotient, zero remainder
    if (wrap_case) begin
      quot_final = dividend_cap_reg;
      rem_final  = ZERO_WORD;
    end
    // (RULE_11) Fixed pattern keeps the zero-divisor result repeatable
    if (zero_div) begin
      quot_final = ALL_ONES;
      rem_final  = dividend_cap_reg;
    end
  end

  reg [WIDTH-1:0] result;
  always @* begin
    case (op_reg)
      // (RULE_06) Signed quotient
      // (RULE_14) Wrap case already folded in
      `OP_SIGNED_QUOT:   result = quot_final;
      // (RULE_07) Signed remainder
      `OP_SIGNED_REM:    result = rem_final;
      // (RULE_08) Unsigned quotient
      `OP_UNSIGNED_QUOT: result = div_quot;
      // (RULE_09) Unsigned remainder
      `OP_UNSIGNED_REM:  result = div_rem;
      default:           result = div_quot;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state_reg          <= S_IDLE;
      op_reg             <= `OP_SIGNED_QUOT;
      dest_reg           <= 5'h00;
      neg_quot_reg       <= 1'b0;
      neg_rem_reg        <= 1'b0;
      write_enable       <= 1'b0;
      write_index        <= 5'h00;
      write_data         <= {WIDTH{1'b0}};
      reserved_instr_exc <= 1'b0;
    end else begin
      write_enable       <= 1'b0;
      reserved_instr_exc <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          // (RULE_12) Reserved instruction pulse
          if (instr_valid && legacy) begin
            reserved_instr_exc <= 1'b1;
          end
          if (start) begin
            op_reg       <= op_code;
            dest_reg     <= dest_reg_field;
            neg_quot_reg <= a_neg ^ b_neg;
            neg_rem_reg  <= a_neg;
            state_reg    <= S_RUN;
          end
        end
        S_RUN: begin
          // (RULE_11) Zero divisor: signed ops write all ones or the dividend, unsigned ops whatever the divider left
          if (div_done) begin
            // (RULE_15) Register zero discarded
            write_enable <= (dest_reg != `ZERO_REG_INDEX);
            // (RULE_04) Single result write
            write_index  <= dest_reg;
            write_data   <= result;
            state_reg    <= S_DONE;
          end
        end
        S_DONE: begin
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> test/regfile_model.sv
// Register file on the far side of the divide unit.
// Assumes combinational reads and one write port sampled on the rising clock.
`timescale 1ns/1ps
`default_nettype none
module regfile_model #(
  parameter WIDTH = 32
) (
  // Clock
  input  wire logic             clock,
  // Read ports
  input  wire logic [4:0]       dividend_read_index,
  input  wire logic [4:0]       divisor_read_index,
  output logic      [WIDTH-1:0] dividend_value,
  output logic      [WIDTH-1:0] divisor_value,
  // Write port
  input  wire logic             write_enable,
  input  wire logic [4:0]       write_index,
  input  wire logic [WIDTH-1:0] write_data
);
  logic [WIDTH-1:0] regs [0:31];
  assign dividend_value = (dividend_read_index == 5'h00) ? '0 : regs[dividend_read_index];
  assign divisor_value  = (divisor_read_index == 5'h00) ? '0 : regs[divisor_read_index];
  always @(posedge clock) begin
    if (write_enable)
      regs[write_index] <= write_data;
  end
endmodule
`default_nettype wire

// >>> test/divide_unit_props.sv
// Checker for issue, write-back and exception timing of the divide unit.
// Assumes it is bound to the unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module divide_unit_props #(
  parameter WIDTH             = 32,
  parameter LEGACY_FUNC_MASK  = 10'h3FF,
  parameter LEGACY_DIV_FUNC   = 10'h2AC,
  parameter LEGACY_UQUOT_FUNC = 10'h2EC
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Issue
  input  wire logic             instr_valid,
  input  wire logic [31:0]      instr,
  input  wire logic             accepted,
  input  wire logic             busy,
  // Write-back and exceptions
  input  wire logic             write_enable,
  input  wire logic [4:0]       write_index,
  input  wire logic             reserved_instr_exc,
  input  wire logic             arith_exc
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic busy_q;
  logic acc_q;
  // A new take starts after idle or straight after the accept cycle
  wire take = busy && (!busy_q || acc_q);
  wire [9:0] fm = instr[9:0] & LEGACY_FUNC_MASK;
  wire legacy = instr_valid && !busy && instr[31:26] == 6'h00 &&
                (fm == (LEGACY_DIV_FUNC & LEGACY_FUNC_MASK) ||
                 fm == (LEGACY_UQUOT_FUNC & LEGACY_FUNC_MASK));
  always @(posedge clock) begin
    busy_q <= busy;
    acc_q  <= accepted;
  end
  sequence s_run;
    ##34 accepted;
  endsequence
  a_write_at_34: assert property (take && instr[15:11] != 5'h00 |-> ##34 write_enable)
    else $error("result write not 34 cycles after issue");
  a_write_index_dest: assert property (take |-> ##34 write_index == $past(instr[15:11], 34))
    else $error("write index differs from destination field");
  a_no_early_write: assert property (take |=> (!write_enable) [*8])
    else $error("write too soon after issue");
  a_busy_until_accept: assert property (take |-> busy throughout s_run)
    else $error("busy dropped before accept");
  a_busy_after_accept: assert property (accepted |=> !busy || instr_valid)
    else $error("busy held after accept");
  a_zero_reg_discard: assert property (write_enable |-> write_index != 5'h00)
    else $error("write to register zero");
  a_no_arith_trap: assert property (!arith_exc)
    else $error("arithmetic exception raised");
  a_legacy_exc_pulse: assert property (legacy |=> reserved_instr_exc ##1 !reserved_instr_exc)
    else $error("legacy encoding without one-cycle exception");
endmodule
bind integer_divide_modulo_unit divide_unit_props #(
  .WIDTH(WIDTH), .LEGACY_FUNC_MASK(LEGACY_FUNC_MASK),
  .LEGACY_DIV_FUNC(LEGACY_DIV_FUNC), .LEGACY_UQUOT_FUNC(LEGACY_UQUOT_FUNC)
) props_i (
  .clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
  .accepted(accepted), .busy(busy), .write_enable(write_enable),
  .write_index(write_index), .reserved_instr_exc(reserved_instr_exc),
  .arith_exc(arith_exc)
);
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the divide unit with a register file model.
// Assumes results land 34 cycles after issue, with accept in that same cycle.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock;
  logic        rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [31:0] instr = 32'h0;
  wire         accepted, busy, write_enable, reserved_instr_exc, arith_exc;
  wire  [4:0]  dividend_read_index, divisor_read_index, write_index;
  wire  [31:0] dividend_value, divisor_value, write_data;
  integer      n_fail = 0;
  integer      check_count = 0;
  // Legacy codes are arbitrary stand-ins for the old encodings
  integer_divide_modulo_unit #(.WIDTH(32), .LEGACY_FUNC_MASK(10'h3FF),
    .LEGACY_DIV_FUNC(10'h2AC), .LEGACY_UQUOT_FUNC(10'h2EC)) integer_divide_modulo_unit_i (
    .clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .accepted(accepted), .busy(busy), .dividend_read_index(dividend_read_index),
    .divisor_read_index(divisor_read_index), .dividend_value(dividend_value),
    .divisor_value(divisor_value), .write_enable(write_enable), .write_index(write_index),
    .write_data(write_data), .reserved_instr_exc(reserved_instr_exc), .arith_exc(arith_exc));
  regfile_model #(.WIDTH(32)) regfile_model_i (
    .clock(clock), .dividend_read_index(dividend_read_index),
    .divisor_read_index(divisor_read_index), .dividend_value(dividend_value),
    .divisor_value(divisor_value), .write_enable(write_enable),
    .write_index(write_index), .write_data(write_data));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Operands go to r1 and r2; instr held until accept is seen
  task automatic issue(input logic [9:0] fn, input logic [4:0] rd, input logic [31:0] a, b);
    integer k;
    @(negedge clock);
    regfile_model_i.regs[1] = a;
    regfile_model_i.regs[2] = b;
    instr = {6'h00, 5'd2, 5'd1, rd, 1'b0, fn};
    instr_valid = 1'b1;
    k = 0;
    while (accepted !== 1'b1 && k < 60) begin
      @(negedge clock);
      k++;
    end
    instr_valid = 1'b0;
    check(32'(k), 32'd34);
    // The write lands on the next rising edge; let it pass before any read
    @(negedge clock);
  endtask
  task t_ops;
    logic [31:0] a [0:1];
    logic [31:0] b [0:1];
    logic [31:0] e [0:3];
    integer      i;
    integer      j;
    a[0] = 32'hFFFFFFF9;
    b[0] = 32'h00000002;
    a[1] = 32'h00000064;
    b[1] = 32'hFFFFFFF9;
    for (i = 0; i < 2; i++) begin
      e[0] = $signed(a[i]) / $signed(b[i]);
      e[1] = $signed(a[i]) % $signed(b[i]);
      e[2] = a[i] / b[i];
      e[3] = a[i] % b[i];
      for (j = 0; j < 4; j++) begin
        issue(10'h118 + 10'(j) * 10'h040, 5'd3, a[i], b[i]);
        check(regfile_model_i.regs[3], e[j]);
      end
    end
    $display("t_ops done");
  endtask
  task t_corner;
    issue(10'h118, 5'd4, 32'h80000000, 32'hFFFFFFFF);
    check(regfile_model_i.regs[4], 32'h80000000);
    issue(10'h158, 5'd4, 32'h80000000, 32'hFFFFFFFF);
    check(regfile_model_i.regs[4], 32'h00000000);
    issue(10'h198, 5'd5, 32'h00000005, 32'h00000000);
    check({31'h0, arith_exc}, 32'h0);
    issue(10'h118, 5'd0, 32'h00000009, 32'h00000003);
    check(regfile_model_i.regs[0], 32'h0);
    $display("t_corner done");
  endtask
  task t_legacy;
    logic [31:0] w [0:3];
    integer      i;
    w[0] = {6'h00, 15'h0443, 1'b0, 10'h2AC};
    w[1] = {6'h00, 15'h0443, 1'b0, 10'h2EC};
    w[2] = {6'h00, 15'h0443, 1'b1, 10'h118};
    w[3] = {6'h01, 15'h0443, 1'b0, 10'h198};
    for (i = 0; i < 4; i++) begin
      @(negedge clock);
      instr = w[i];
      instr_valid = 1'b1;
      #1;
      check({31'h0, busy}, 32'h0);
      @(negedge clock);
      instr_valid = 1'b0;
      check({31'h0, reserved_instr_exc}, (i < 2) ? 32'h1 : 32'h0);
    end
    $display("t_legacy done");
  endtask
  initial begin
    regfile_model_i.regs[0] = 32'h0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_ops;
    t_corner;
    t_legacy;
    conclude;
  end
  initial begin
    #10000;
    n_fail++;
    conclude;
  end
endmodule
`default_nettype wire
